// file: atr_edge_sampler.sv
// Samples one external pin with the basic clock and reports its edges.
// Assumes the pin is asynchronous to clk and held stable a full sample period.
module atr_edge_sampler (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                basic_tick,
  input  wire logic                pin,
  output logic                     rise,
  output logic                     fall
);
  import atr_pkg::*;

  logic sync1_q;
  logic sync2_q;
  logic samp_q;
  logic rise_q;
  logic fall_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Sample and compare with the previous sample
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      samp_q <= 1'b0;
      rise_q <= 1'b0;
      fall_q <= 1'b0;
    end else begin
      if (basic_tick) begin
        samp_q <= sync2_q;  // see RL15
      end
      rise_q <= basic_tick & sync2_q & ~samp_q;  // see RL22
      fall_q <= basic_tick & ~sync2_q & samp_q;  // see RL22
    end
  end

  assign rise = rise_q;
  assign fall = fall_q;

  a_edge_on_tick: assert property (@(posedge clk) disable iff (!rst_n)  // see RL15
    (rise_q || fall_q) |-> $past(basic_tick) && !(rise_q && fall_q))
    else $error("Input edge reported off the basic clock");

endmodule : atr_edge_sampler

// file: atr_pin_src.sv
// Model of the external sources on the auxiliary input pins.
// Assumes level requests come from the bench on the rising clk edge.
module atr_pin_src #(
  parameter int HOLD = 32
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [1:0] lvl_req,
  output logic      [1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  int cnt_q;
  // Pins are plain inputs; each level stands a full sample period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin   <= 2'h0;
      cnt_q <= 0;
    end else if (lvl_req != pin && cnt_q >= HOLD) begin
      pin   <= lvl_req;
      cnt_q <= 0;
    end else if (cnt_q < HOLD) begin
      cnt_q <= cnt_q + 1;
    end
  end
endmodule : atr_pin_src

// file: atr_pkg.sv
// Constants shared by the auxiliary timer reload and capture block.
// Assumes a 32-bit APB slave port and a single 250 MHz module clock.
package atr_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ATR_OFS_CORE_CTRL = 8'h00;
  localparam logic [7:0] ATR_OFS_CORE_CNT  = 8'h04;
  localparam logic [7:0] ATR_OFS_AUX_CTRL0 = 8'h08;
  localparam logic [7:0] ATR_OFS_AUX_CTRL1 = 8'h0c;
  localparam logic [7:0] ATR_OFS_AUX_CNT0  = 8'h10;
  localparam logic [7:0] ATR_OFS_AUX_CNT1  = 8'h14;
  localparam logic [7:0] ATR_OFS_IRQ       = 8'h18;

  // ----------------------------------------------------------------
  // Core control fields
  // ----------------------------------------------------------------
  localparam int ATR_CC_SEL_LSB  = 0;
  localparam int ATR_CC_DOWN_BIT = 3;
  localparam int ATR_CC_RUN_BIT  = 4;
  localparam int ATR_CC_BPS_LSB  = 5;
  localparam int ATR_CC_OE_BIT   = 7;
  localparam int ATR_CC_OTL_BIT  = 8;

  // ----------------------------------------------------------------
  // Auxiliary control fields
  // ----------------------------------------------------------------
  localparam int ATR_AC_SEL_LSB  = 0;
  localparam int ATR_AC_MODE_LSB = 3;
  localparam int ATR_AC_RUN_BIT  = 6;
  localparam int ATR_AC_DOWN_BIT = 7;

  // ----------------------------------------------------------------
  // Interrupt flag positions
  // ----------------------------------------------------------------
  localparam int ATR_IRQ_CORE_BIT = 0;
  localparam int ATR_IRQ_AUX_LSB  = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  ATR_BPS_RESET   = 2'h0;
  localparam logic [15:0] ATR_CNT_RESET   = 16'h0000;
  localparam logic [2:0]  ATR_FIELD_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Block prescaler encodings and terminal counts (factor minus one)
  // ----------------------------------------------------------------
  localparam logic [1:0] ATR_BPS_DIV4  = 2'h1;
  localparam logic [1:0] ATR_BPS_DIV8  = 2'h0;
  localparam logic [1:0] ATR_BPS_DIV16 = 2'h3;
  localparam logic [1:0] ATR_BPS_DIV32 = 2'h2;
  localparam logic [4:0] ATR_LIM_DIV4  = 5'h03;
  localparam logic [4:0] ATR_LIM_DIV8  = 5'h07;
  localparam logic [4:0] ATR_LIM_DIV16 = 5'h0f;
  localparam logic [4:0] ATR_LIM_DIV32 = 5'h1f;

  // ----------------------------------------------------------------
  // Auxiliary modes
  // ----------------------------------------------------------------
  localparam logic [2:0] ATR_MODE_TIMER   = 3'h0;
  localparam logic [2:0] ATR_MODE_COUNTER = 3'h1;
  localparam logic [2:0] ATR_MODE_RELOAD  = 3'h4;
  localparam logic [2:0] ATR_MODE_CAPTURE = 3'h5;

  localparam logic [15:0] ATR_CNT_MAX = 16'hffff;

endpackage : atr_pkg

// file: atr_prescaler.sv
// Block prescaler: makes the basic clock tick and the input prescaler count.
// Assumes the select field comes from a register on the same clock.
module atr_prescaler (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic [1:0]          block_prescaler_select,
  output logic                     basic_tick,
  output logic [6:0]               pre_cnt
);
  import atr_pkg::*;

  logic [4:0] div_q;
  logic [4:0] lim;
  logic       tick_q;
  logic [6:0] pre_q;

  // ----------------------------------------------------------------
  // Divider factor decode
  // ----------------------------------------------------------------
  always_comb begin
    case (block_prescaler_select)
      ATR_BPS_DIV4:  lim = ATR_LIM_DIV4;   // see RL13
      ATR_BPS_DIV8:  lim = ATR_LIM_DIV8;   // see RL13
      ATR_BPS_DIV16: lim = ATR_LIM_DIV16;  // see RL13
      ATR_BPS_DIV32: lim = ATR_LIM_DIV32;  // see RL13
      default:       lim = ATR_LIM_DIV8;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q  <= 5'h00;
      tick_q <= 1'b0;
    end else begin
      div_q  <= (div_q >= lim) ? 5'h00 : div_q + 5'h01;  // see RL12
      tick_q <= (div_q >= lim);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pre_q <= 7'h00;
    end else if (tick_q) begin
      pre_q <= pre_q + 7'h01;  // see RL14
    end
  end

  assign basic_tick = tick_q;
  assign pre_cnt    = pre_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  logic [4:0] gap_q;
  logic [1:0] bps_prev_q;
  logic       stable_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gap_q      <= 5'h00;
      bps_prev_q <= ATR_BPS_RESET;
      stable_q   <= 1'b0;
    end else begin
      gap_q      <= tick_q ? 5'h00 : gap_q + 5'h01;
      bps_prev_q <= block_prescaler_select;
      if (bps_prev_q != block_prescaler_select) begin
        stable_q <= 1'b0;
      end else if (tick_q) begin
        stable_q <= 1'b1;
      end
    end
  end

  a_basic_period: assert property (@(posedge clk) disable iff (!rst_n)  // see RL13
    tick_q && stable_q && (bps_prev_q == block_prescaler_select) |-> gap_q == lim)
    else $error("Basic clock period does not match block prescaler");

endmodule : atr_prescaler

// file: atr_timer_block.sv
// Core timer with two auxiliary timers in reload, capture, timer and counter modes.
// Assumes an APB master on clk and asynchronous external input pins.
//
// Overview of operation
// RL1: Reload on both latch edges reloads core on every overflow or underflow.
// RL2: Reload on one latch edge reloads core on every second overflow.
// RL3: Rising and falling reload sources alternate, giving PWM on the latch.
// RL4: Toggle output pin shows the latch whenever its enable bit is one.
// RL5: Software writes to the latch never trigger a reload.
// RL6: Same reload trigger on both auxiliaries: second auxiliary value wins.
// RL7: Mode 101 captures core timer into auxiliary on selected pin edge.
// RL8: Software picks capture edge with select low bits, keeps bit 2 clear.
// RL9: Auxiliary timer never counts in capture mode, run flag ignored.
// RL10: Capture sets the auxiliary interrupt flag together with storing.
// RL11: Software configures the auxiliary pin as an input before capture.
// RL12: All actions happen on basic clock, module clock over block prescaler.
// RL13: Block prescaler 01 div 4, 00 div 8, 11 div 16, 10 div 32.
// RL14: Timer mode count clock is basic clock over two to the select.
// RL15: Inputs sampled on basic clock; edge when two samples differ.
// RL16: Sources hold each input level one full sample period.
// RL17: Same sampling applies to every external input of the block.
// RL18: Mode 100 is reload; auxiliary register feeds the core timer.
// RL19: Reload trigger loads core and sets that auxiliary interrupt flag.
// RL20: Selects 101 to 111 pick latch edges, 001 to 011 pin edges.
// RL21: All timers are 16 bits and transfer whole in one action.
// RL22: Edges come from comparing current and previous registered samples.
//
// Our own choices: the APB slave port and the address map.
module atr_timer_block (
  input  wire logic                clk,
  input  wire logic                rst_n,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [1:0]          aux_input_pin,
  output logic                     toggle_output_pin,
  output logic [2:0]               aux_interrupt_flag
);
  import atr_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic        basic_tick;
  logic [6:0]  pre_cnt;
  logic [1:0]  pin_rise;
  logic [1:0]  pin_fall;
  logic [2:0]  core_sel_q;
  logic        core_down_q;
  logic        core_run_q;
  logic [1:0]  block_prescaler_select_q;
  logic        toggle_output_enable_q;
  logic        core_overflow_toggle_latch_q;
  logic [15:0] core_timer_q;
  logic [2:0]  input_select_field_q [2];
  logic [2:0]  aux_mode_field_q     [2];
  logic [1:0]  aux_run_q;
  logic [1:0]  aux_down_q;
  logic [15:0] aux_timer_q          [2];
  logic [2:0]  irq_q;
  logic        toggle_out_q;
  logic [31:0] prdata_q;
  logic        wr_en;
  logic        setup;
  logic        core_tick;
  logic        core_ovf;
  logic        latch_rise;
  logic        latch_fall;
  logic [1:0]  rl_fire;
  logic [1:0]  cap_fire;
  logic [1:0]  aux_ovf;
  logic [1:0]  aux_wr;
  logic [1:0]  aux_ctrl_wr;

  // ----------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------
  function automatic logic count_tick(input logic [2:0] sel, input logic [6:0] pre,
                                      input logic tick);
    logic [6:0] m;
    m = 7'(8'h01 << sel) - 7'h01;
    count_tick = tick & ((pre & m) == m);
  endfunction : count_tick

  function automatic logic trig_hit(input logic [2:0] sel, input logic pr, input logic pf,
                                    input logic lr, input logic lf);
    case (sel)
      3'h1:    trig_hit = pr;
      3'h2:    trig_hit = pf;
      3'h3:    trig_hit = pr | pf;
      3'h5:    trig_hit = lr;
      3'h6:    trig_hit = lf;
      3'h7:    trig_hit = lr | lf;
      default: trig_hit = 1'b0;
    endcase
  endfunction : trig_hit

  // ----------------------------------------------------------------
  // Clocking and input sampling
  // ----------------------------------------------------------------
  atr_prescaler u_prescaler (
    .clk                    (clk),
    .rst_n                  (rst_n),
    .block_prescaler_select (block_prescaler_select_q),
    .basic_tick             (basic_tick),
    .pre_cnt                (pre_cnt)
  );

  for (genvar i = 0; i < 2; i++) begin : g_sampler
    atr_edge_sampler u_sampler (
      .clk        (clk),
      .rst_n      (rst_n),
      .basic_tick (basic_tick),
      .pin        (aux_input_pin[i]),
      .rise       (pin_rise[i]),
      .fall       (pin_fall[i])
    );  // see RL17
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  assign setup   = psel & ~penable;
  assign wr_en   = psel & penable & pwrite;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & (paddr > ATR_OFS_IRQ || paddr[1:0] != 2'h0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup) begin
      case (paddr)
        ATR_OFS_CORE_CTRL: prdata_q <= {23'h0, core_overflow_toggle_latch_q, toggle_output_enable_q,
                                        block_prescaler_select_q, core_run_q, core_down_q, core_sel_q};
        ATR_OFS_CORE_CNT:  prdata_q <= {16'h0, core_timer_q};
        ATR_OFS_AUX_CTRL0: prdata_q <= {24'h0, aux_down_q[0], aux_run_q[0], aux_mode_field_q[0],
                                        input_select_field_q[0]};
        ATR_OFS_AUX_CTRL1: prdata_q <= {24'h0, aux_down_q[1], aux_run_q[1], aux_mode_field_q[1],
                                        input_select_field_q[1]};
        ATR_OFS_AUX_CNT0:  prdata_q <= {16'h0, aux_timer_q[0]};
        ATR_OFS_AUX_CNT1:  prdata_q <= {16'h0, aux_timer_q[1]};
        ATR_OFS_IRQ:       prdata_q <= {29'h0, irq_q};
        default:           prdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign prdata = prdata_q;

  // ----------------------------------------------------------------
  // Core control register
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_sel_q               <= ATR_FIELD_RESET;
      core_down_q              <= 1'b0;
      core_run_q               <= 1'b0;
      block_prescaler_select_q <= ATR_BPS_RESET;
      toggle_output_enable_q   <= 1'b0;
    end else if (wr_en && paddr == ATR_OFS_CORE_CTRL) begin
      core_sel_q               <= pwdata[ATR_CC_SEL_LSB +: 3];
      core_down_q              <= pwdata[ATR_CC_DOWN_BIT];
      core_run_q               <= pwdata[ATR_CC_RUN_BIT];
      block_prescaler_select_q <= pwdata[ATR_CC_BPS_LSB +: 2];
      toggle_output_enable_q   <= pwdata[ATR_CC_OE_BIT];
    end
  end

  // ----------------------------------------------------------------
  // Core timer and overflow toggle latch
  // ----------------------------------------------------------------
  assign core_tick  = count_tick(core_sel_q, pre_cnt, basic_tick) & core_run_q;  // see RL14
  assign core_ovf   = core_tick & (core_down_q ? (core_timer_q == 16'h0000) : (core_timer_q == ATR_CNT_MAX));
  assign latch_rise = core_ovf & ~core_overflow_toggle_latch_q;  // see RL5
  assign latch_fall = core_ovf & core_overflow_toggle_latch_q;   // see RL5

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_overflow_toggle_latch_q <= 1'b0;
    end else if (wr_en && paddr == ATR_OFS_CORE_CTRL) begin
      core_overflow_toggle_latch_q <= pwdata[ATR_CC_OTL_BIT];
    end else if (core_ovf) begin
      core_overflow_toggle_latch_q <= ~core_overflow_toggle_latch_q;  // see RL3
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_timer_q <= ATR_CNT_RESET;
    end else if (wr_en && paddr == ATR_OFS_CORE_CNT) begin
      core_timer_q <= pwdata[15:0];
    end else if (rl_fire[1]) begin
      core_timer_q <= aux_timer_q[1];  // see RL6
    end else if (rl_fire[0]) begin
      core_timer_q <= aux_timer_q[0];  // see RL19
    end else if (core_tick) begin
      core_timer_q <= core_down_q ? core_timer_q - 16'h0001 : core_timer_q + 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_out_q <= 1'b0;
    end else begin
      toggle_out_q <= toggle_output_enable_q & core_overflow_toggle_latch_q;  // see RL4
    end
  end

  assign toggle_output_pin = toggle_out_q;

  // ----------------------------------------------------------------
  // Auxiliary timers
  // ----------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_aux
    logic cnt_ev;

    assign aux_ctrl_wr[i] = wr_en && paddr == (i == 0 ? ATR_OFS_AUX_CTRL0 : ATR_OFS_AUX_CTRL1);
    assign aux_wr[i]      = wr_en && paddr == (i == 0 ? ATR_OFS_AUX_CNT0 : ATR_OFS_AUX_CNT1);
    assign rl_fire[i]     = (aux_mode_field_q[i] == ATR_MODE_RELOAD) &
                            trig_hit(input_select_field_q[i], pin_rise[i], pin_fall[i],
                                     latch_rise, latch_fall);  // see RL1, see RL2, see RL18, see RL20
    assign cap_fire[i]    = (aux_mode_field_q[i] == ATR_MODE_CAPTURE) &
                            trig_hit({1'b0, input_select_field_q[i][1:0]}, pin_rise[i], pin_fall[i],
                                     1'b0, 1'b0);  // see RL7, see RL8
    assign cnt_ev         = (aux_mode_field_q[i] == ATR_MODE_TIMER) ?
                            (aux_run_q[i] & count_tick(input_select_field_q[i], pre_cnt, basic_tick)) :
                            (aux_mode_field_q[i] == ATR_MODE_COUNTER) ?
                            (aux_run_q[i] & trig_hit(input_select_field_q[i], pin_rise[i], pin_fall[i],
                                                     latch_rise, latch_fall)) : 1'b0;  // see RL9
    assign aux_ovf[i]     = cnt_ev & (aux_down_q[i] ? (aux_timer_q[i] == 16'h0000) :
                                                      (aux_timer_q[i] == ATR_CNT_MAX));

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        input_select_field_q[i] <= ATR_FIELD_RESET;
        aux_mode_field_q[i]     <= ATR_FIELD_RESET;
        aux_run_q[i]            <= 1'b0;
        aux_down_q[i]           <= 1'b0;
      end else if (aux_ctrl_wr[i]) begin
        input_select_field_q[i] <= pwdata[ATR_AC_SEL_LSB +: 3];
        aux_mode_field_q[i]     <= pwdata[ATR_AC_MODE_LSB +: 3];
        aux_run_q[i]            <= pwdata[ATR_AC_RUN_BIT];
        aux_down_q[i]           <= pwdata[ATR_AC_DOWN_BIT];
      end
    end

    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        aux_timer_q[i] <= ATR_CNT_RESET;
      end else if (aux_wr[i]) begin
        aux_timer_q[i] <= pwdata[15:0];
      end else if (cap_fire[i]) begin
        aux_timer_q[i] <= core_timer_q;  // see RL7, see RL21
      end else if (cnt_ev) begin
        aux_timer_q[i] <= aux_down_q[i] ? aux_timer_q[i] - 16'h0001 : aux_timer_q[i] + 16'h0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags, set wins over write-one-to-clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_q <= 3'h0;
    end else begin
      irq_q <= (irq_q & ~((wr_en && paddr == ATR_OFS_IRQ) ? pwdata[2:0] : 3'h0)) |
               {rl_fire[1] | cap_fire[1] | aux_ovf[1],
                rl_fire[0] | cap_fire[0] | aux_ovf[0], core_ovf};  // see RL10, see RL19
    end
  end

  assign aux_interrupt_flag = irq_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_toggle_out_follow: assert property (  // see RL4
    ##1 toggle_output_pin == $past(toggle_output_enable_q & core_overflow_toggle_latch_q))
    else $error("Toggle output does not follow latch and enable");

  a_reload_needs_event: assert property (  // see RL5
    rl_fire[0] || rl_fire[1] |-> core_ovf || (|pin_rise) || (|pin_fall))
    else $error("Reload without overflow or pin edge");

  a_reload_both_edges: assert property (  // see RL1
    core_ovf && aux_mode_field_q[0] == ATR_MODE_RELOAD && input_select_field_q[0] == 3'h7 &&
    !rl_fire[1] && !(wr_en && paddr == ATR_OFS_CORE_CNT) |=> core_timer_q == $past(aux_timer_q[0]))
    else $error("Core not reloaded on overflow");

  a_reload_one_edge: assert property (  // see RL2
    core_ovf && core_overflow_toggle_latch_q && aux_mode_field_q[0] == ATR_MODE_RELOAD &&
    input_select_field_q[0] == 3'h5 |-> !rl_fire[0])
    else $error("Single edge reload fired on wrong overflow");

  a_second_aux_wins: assert property (  // see RL6
    rl_fire[0] && rl_fire[1] && !(wr_en && paddr == ATR_OFS_CORE_CNT) |=> core_timer_q == $past(aux_timer_q[1]))
    else $error("First auxiliary not disregarded");

  a_capture_store: assert property (  // see RL7
    cap_fire[0] && !aux_wr[0] |=> aux_timer_q[0] == $past(core_timer_q) && irq_q[ATR_IRQ_AUX_LSB])
    else $error("Capture did not store core value and set flag");

  a_capture_no_count: assert property (  // see RL9
    aux_mode_field_q[0] == ATR_MODE_CAPTURE && !cap_fire[0] && !aux_wr[0] |=>
    aux_timer_q[0] == $past(aux_timer_q[0]))
    else $error("Auxiliary counted in capture mode");

  a_latch_toggles: assert property (  // see RL3
    core_ovf && !(wr_en && paddr == ATR_OFS_CORE_CTRL) |=>
    core_overflow_toggle_latch_q != $past(core_overflow_toggle_latch_q))
    else $error("Latch did not toggle on overflow");

  a_reload_flag_set: assert property (  // see RL19
    rl_fire[1] |=> irq_q[ATR_IRQ_AUX_LSB + 1])
    else $error("Reload did not set auxiliary flag");

endmodule : atr_timer_block

// file: atr_timer_block_tb.sv
// Self-checking bench for the timer block.
// Assumes an APB slave and pin sources from atr_pin_src.
module atr_timer_block_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import atr_pkg::*;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, toggle_output_pin;
  logic [1:0] lvl = 2'h0, aux_input_pin;
  logic [2:0] aux_interrupt_flag;
  int mismatches = 0, checks = 0;
  // Rows: select, start level, end level, capture expected
  localparam logic [5:0] ROWS [6] = '{6'h0b, 6'h0c, 6'h15, 6'h12, 6'h1b, 6'h1d};
  atr_timer_block i_dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .aux_input_pin(aux_input_pin),
    .toggle_output_pin(toggle_output_pin), .aux_interrupt_flag(aux_interrupt_flag));
  atr_pin_src i_src (.clk(clk), .rst_n(rst_n), .lvl_req(lvl), .pin(aux_input_pin));
  always #2 clk = ~clk;
  task automatic stop_test();
    if (mismatches == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : stop_test
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      mismatches++;
      stop_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb
  // Measures one high and one low phase of the toggle pin, after a full fall
  task automatic meas(int hi, int lo);
    int n, h, l;
    n = 0;
    h = 0;
    l = 0;
    while (toggle_output_pin !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    while (toggle_output_pin !== 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
    end
    while (toggle_output_pin !== 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
    end
    while (toggle_output_pin === 1'b1 && n < 300) begin
      @(posedge clk);
      n++;
      h++;
    end
    while (toggle_output_pin === 1'b0 && n < 300) begin
      @(posedge clk);
      n++;
      l++;
    end
    if (n >= 300) begin
      mismatches++;
      stop_test();
    end
    chk("pwm_high", hi, h);
    chk("pwm_low", lo, l);
  endtask : meas
  initial begin
    repeat (50000) @(posedge clk);
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk) lvl <= {1'b0, ROWS[i][2]};
      repeat (80) @(posedge clk);
      apb(1, ATR_OFS_AUX_CNT0, 0);
      apb(1, ATR_OFS_IRQ, 7);
      apb(1, ATR_OFS_CORE_CNT, 32'h1230 + i);
      apb(1, ATR_OFS_AUX_CTRL0, 32'h68 | ROWS[i][5:3]);
      @(posedge clk) lvl <= {1'b0, ROWS[i][1]};
      repeat (80) @(posedge clk);
      apb(0, ATR_OFS_AUX_CNT0, 0);
      chk("aux_cnt0", ROWS[i][0] ? 32'h1230 + i : 32'h0, rd);
      apb(0, ATR_OFS_IRQ, 0);
      chk("irq", {29'h0, 1'b0, ROWS[i][0], 1'b0}, rd);
      chk("irq_out", {29'h0, 1'b0, ROWS[i][0], 1'b0}, {29'h0, aux_interrupt_flag});
    end
    apb(0, ATR_OFS_CORE_CTRL, 0);
    chk("core_ctrl", 32'h0, rd);
    apb(0, 8'h1c, 0);
    chk("pslverr", 32'h1, {31'h0, err});
    apb(1, ATR_OFS_AUX_CNT1, 32'hbeef);
    apb(1, ATR_OFS_AUX_CTRL1, 32'h21);
    @(posedge clk) lvl <= {1'b1, lvl[0]};
    repeat (80) @(posedge clk);
    apb(0, ATR_OFS_CORE_CNT, 0);
    chk("core_cnt", 32'hbeef, rd);
    chk("irq_flag2", 32'h1, {31'h0, aux_interrupt_flag[2]});
    apb(1, ATR_OFS_IRQ, 7);
    apb(1, ATR_OFS_AUX_CTRL0, 32'h27);
    apb(1, ATR_OFS_AUX_CTRL1, 32'h27);
    apb(1, ATR_OFS_AUX_CNT0, 32'hfff0);
    apb(1, ATR_OFS_AUX_CNT1, 32'heee0);
    apb(1, ATR_OFS_CORE_CNT, 32'hffff);
    apb(1, ATR_OFS_CORE_CTRL, 32'h180);
    repeat (4) @(posedge clk);
    chk("toggle_pin", 32'h1, {31'h0, toggle_output_pin});
    apb(0, ATR_OFS_CORE_CNT, 0);
    chk("core_cnt", 32'hffff, rd);
    apb(1, ATR_OFS_CORE_CTRL, 32'h1b0);
    repeat (10) @(posedge clk);
    apb(1, ATR_OFS_CORE_CTRL, 32'h0a0);
    apb(0, ATR_OFS_CORE_CNT, 0);
    chk("core_cnt", 32'heee0, rd & 32'hfff0);
    apb(1, ATR_OFS_AUX_CTRL0, 32'h25);
    apb(1, ATR_OFS_AUX_CTRL1, 32'h26);
    apb(1, ATR_OFS_AUX_CNT0, 32'hfffe);
    apb(1, ATR_OFS_AUX_CNT1, 32'hfffc);
    apb(1, ATR_OFS_CORE_CNT, 32'hffff);
    apb(1, ATR_OFS_CORE_CTRL, 32'h0b0);
    meas(8, 16);
    apb(1, ATR_OFS_AUX_CTRL0, 32'h27);
    apb(1, ATR_OFS_AUX_CTRL1, 32'h0);
    meas(8, 8);
    stop_test();
  end
endmodule : atr_timer_block_tb
